// File: include/uart_flag_pkg.sv
// Purpose: shared constants and types of the serial status flag block
// Assumes: avalon-mm register slave, 32-bit data, word addressed by byte address
// Notes: offsets are byte addresses of aligned words
package uart_flag_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_RXDATA = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_TXDATA = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ST = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 5'h10;
  // status bit positions
  localparam int BIT_PERR = 0;
  localparam int BIT_FERR = 1;
  localparam int BIT_OVERRUN_ERROR_FLAG = 2;
  localparam int BIT_RX_BUFFER_FULL_FLAG = 3;
  localparam int BIT_TX_BUFFER_FULL_FLAG = 4;
  localparam int BIT_TX_BUSY_FLAG = 5;
  localparam int RX_FLAGS = 4;
  // interrupt status / mask bit positions (same layout in both registers)
  localparam int IRQ_RX = 0;
  localparam int IRQ_TX = 1;
  localparam int IRQ_N = 2;
  // reset values
  localparam logic [BYTE_W-1:0] RST_BYTE = 8'h00;
  localparam logic [IRQ_N-1:0] RST_MASK = 2'h0;
  localparam logic [DATA_W-1:0] UNMAPPED_RD = 32'h0000_0000;
  // bus answer state
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK = 2'b01
  } bus_st_t;
endpackage

// File: include/rx_event_if.sv
// Purpose: carries completed-frame events from the frame checker to the flag logic
// Assumes: single clock domain
// Notes: done is a one-cycle pulse
`timescale 1ns/100ps
interface rx_event_if;
  logic done;
  logic [7:0] data;
  logic perr;
  logic ferr;
  modport src (output done, output data, output perr, output ferr);
  modport dst (input done, input data, input perr, input ferr);
endinterface

// File: design/rx_frame_check.sv
// Purpose: judges a completed receive frame for parity and stop-bit errors
// Assumes: datapath presents data, parity and stop sample with the done pulse
// Notes: combinational; the flag logic registers everything it keeps
`timescale 1ns/100ps
module rx_frame_check (
  // frame from the shift datapath
  input wire logic frame_done,
  input wire logic [7:0] frame_data,
  input wire logic parity_bit,
  input wire logic parity_en,
  input wire logic parity_odd,
  input wire logic stop_sample,
  // judged event
  rx_event_if.src ev
);
  logic calc_par;
  always_comb begin
    calc_par = (^frame_data) ^ parity_odd;
    ev.done = frame_done;
    ev.data = frame_data;
    ev.perr = parity_en & (calc_par != parity_bit);
    ev.ferr = ~stop_sample;
  end
endmodule // rx_frame_check

// File: design/rx_byte_reg.sv
// Purpose: one-byte receive data holding register with registered read data
// Assumes: load and read never need the same cycle ordering beyond write-first
// Notes: small memory of its own
`timescale 1ns/100ps
module rx_byte_reg #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // write side
  input wire logic wr_en,
  input wire logic [W-1:0] wr_data,
  // read side
  output logic [W-1:0] rd_data
);
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data <= '0;
    end else if (wr_en) begin
      rd_data <= wr_data;
    end
  end
endmodule // rx_byte_reg

// File: design/uart_status_flag_logic.sv
// Purpose: status flags, interrupt requests and register slave of the serial port
// Assumes: avalon-mm master per standard; datapath pulses are single-cycle
// Notes: receive flags clear by a status read then a receive data read
`timescale 1ns/100ps
// Function
// - parity mismatch sets parity error flag and raises receive interrupt.
// - data read that clears a parity error returns undefined value.
// - stop bit sampled as zero sets framing error and receive interrupt.
// - frame finishing while buffer unread sets overrun, interrupts, keeps old byte.
// - while overrun set, later frames are discarded with no receive interrupt.
// - discarded frames never touch parity or framing error flags.
// - loading a byte into the receive buffer sets buffer-full flag.
// - data read clears a receive flag only if last status read showed it.
// - flag set after status read survives the next data read.
// - transmit end with empty buffer clears transmit busy flag.
// - restart after buffer write sets transmit busy and transmit interrupt.
// - buffered byte entering shifter clears buffer-full and raises transmit interrupt.
// - software write of transmit buffer sets transmit buffer-full flag.
module uart_status_flag_logic
  import uart_flag_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire logic [uart_flag_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [uart_flag_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [uart_flag_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // receive datapath
  input wire logic rx_frame_done,
  input wire logic [7:0] rx_frame_data,
  input wire logic rx_parity_bit,
  input wire logic rx_parity_en,
  input wire logic rx_parity_odd,
  input wire logic rx_stop_sample,
  // transmit datapath
  input wire logic tx_shift_idle,
  input wire logic tx_done,
  output logic tx_start,
  output logic [7:0] tx_data_out,
  // interrupt requests
  output logic rx_interrupt_request,
  output logic tx_interrupt_request,
  output logic irq
);
  import uart_flag_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    bus_st_t bus;
    logic [DATA_W-1:0] rdata;
    logic perr;
    logic ferr;
    logic overrun_error_flag;
    logic rx_buffer_full_flag;
    logic [RX_FLAGS-1:0] snap;
    logic tx_buffer_full_flag;
    logic tx_busy_flag;
    logic [BYTE_W-1:0] tbuf;
    logic [BYTE_W-1:0] tshift;
    logic start;
    logic rx_irq;
    logic tx_irq;
    logic [IRQ_N-1:0] ist;
    logic [IRQ_N-1:0] imask;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  rx_event_if ev ();
  logic [BYTE_W-1:0] rx_buf;
  logic rx_load;
  logic sel_stat;
  logic sel_rx;
  logic sel_tx;
  logic sel_ist;
  logic sel_msk;
  logic [DATA_W-1:0] stat_word;
  logic rx_kept;

  rx_frame_check u_check (
    .frame_done(rx_frame_done),
    .frame_data(rx_frame_data),
    .parity_bit(rx_parity_bit),
    .parity_en(rx_parity_en),
    .parity_odd(rx_parity_odd),
    .stop_sample(rx_stop_sample),
    .ev(ev)
  );

  rx_byte_reg #(.W(BYTE_W)) u_rxbuf (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .wr_en(rx_load),
    .wr_data(ev.data),
    .rd_data(rx_buf)
  );

  // ************************************************************
  // address decode
  // ************************************************************
  always_comb begin
    sel_stat = 1'b0;
    sel_rx = 1'b0;
    sel_tx = 1'b0;
    sel_ist = 1'b0;
    sel_msk = 1'b0;
    if (avs_address == OFS_STATUS) begin
      sel_stat = 1'b1;
    end else if (avs_address == OFS_RXDATA) begin
      sel_rx = 1'b1;
    end else if (avs_address == OFS_TXDATA) begin
      sel_tx = 1'b1;
    end else if (avs_address == OFS_IRQ_ST) begin
      sel_ist = 1'b1;
    end else if (avs_address == OFS_IRQ_MASK) begin
      sel_msk = 1'b1;
    end
  end

  always_comb begin
    stat_word = '0;
    stat_word[BIT_PERR] = st_ff.perr;
    stat_word[BIT_FERR] = st_ff.ferr;
    stat_word[BIT_OVERRUN_ERROR_FLAG] = st_ff.overrun_error_flag;
    stat_word[BIT_RX_BUFFER_FULL_FLAG] = st_ff.rx_buffer_full_flag;
    stat_word[BIT_TX_BUFFER_FULL_FLAG] = st_ff.tx_buffer_full_flag;
    stat_word[BIT_TX_BUSY_FLAG] = st_ff.tx_busy_flag;
  end

  // byte is accepted only with no overrun pending and buffer empty
  assign rx_kept = ev.done && !st_ff.rx_buffer_full_flag && !st_ff.overrun_error_flag;
  assign rx_load = rx_kept;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic bus_go;
    logic rd_stat;
    logic rd_rx;
    logic wr_tx;
    logic rx_ev;
    logic tx_ev;
    logic load_tx;
    bus_go = 1'b0;
    rd_stat = 1'b0;
    rd_rx = 1'b0;
    wr_tx = 1'b0;
    rx_ev = 1'b0;
    tx_ev = 1'b0;
    load_tx = 1'b0;
    nxt_st = st_ff;
    nxt_st.start = 1'b0;

    // one wait cycle per access; answer given in BUS_ACK
    case (st_ff.bus)
      BUS_IDLE: begin
        if (avs_read || avs_write) begin
          nxt_st.bus = BUS_ACK;
        end
      end
      default: begin
        bus_go = 1'b1;
        nxt_st.bus = BUS_IDLE;
      end
    endcase
    rd_stat = bus_go && avs_read && sel_stat;
    rd_rx = bus_go && avs_read && sel_rx;
    wr_tx = bus_go && avs_write && sel_tx && avs_byteenable[0];

    if (st_ff.bus == BUS_IDLE && avs_read) begin
      if (sel_stat) begin
        nxt_st.rdata = stat_word;
      end else if (sel_rx) begin
        // a parity-error byte reads as whatever the buffer holds: undefined
        nxt_st.rdata = {24'h000000, rx_buf};
      end else if (sel_ist) begin
        nxt_st.rdata = {30'h00000000, st_ff.ist};
      end else if (sel_msk) begin
        nxt_st.rdata = {30'h00000000, st_ff.imask};
      end else begin
        nxt_st.rdata = UNMAPPED_RD;
      end
    end

    // clears first so that same-cycle sets below win
    if (rd_rx) begin
      if (st_ff.snap[BIT_PERR]) nxt_st.perr = 1'b0;
      if (st_ff.snap[BIT_FERR]) nxt_st.ferr = 1'b0;
      if (st_ff.snap[BIT_OVERRUN_ERROR_FLAG]) nxt_st.overrun_error_flag = 1'b0;
      if (st_ff.snap[BIT_RX_BUFFER_FULL_FLAG]) nxt_st.rx_buffer_full_flag = 1'b0;
      nxt_st.snap = '0;
    end
    // snapshot what the read returned, not the live flags, so an unseen flag survives
    if (rd_stat) begin
      nxt_st.snap = {st_ff.rdata[BIT_RX_BUFFER_FULL_FLAG], st_ff.rdata[BIT_OVERRUN_ERROR_FLAG],
                     st_ff.rdata[BIT_FERR], st_ff.rdata[BIT_PERR]};
    end

    // receive events
    if (ev.done) begin
      if (rx_kept) begin
        nxt_st.rx_buffer_full_flag = 1'b1;
        nxt_st.perr = ev.perr;
        nxt_st.ferr = ev.ferr;
        rx_ev = 1'b1;
      end else begin
        // set wins over a clearing data read in the same cycle
        nxt_st.overrun_error_flag = 1'b1;
        rx_ev = !st_ff.overrun_error_flag;
      end
      // further frames during overrun: dropped, no interrupt, no error update
    end

    // transmit side
    if (wr_tx) begin
      nxt_st.tbuf = avs_writedata[7:0];
      nxt_st.tx_buffer_full_flag = 1'b1;
    end
    load_tx = st_ff.tx_buffer_full_flag && tx_shift_idle && !st_ff.start;
    if (load_tx) begin
      nxt_st.tshift = st_ff.tbuf;
      nxt_st.start = 1'b1;
      if (!wr_tx) nxt_st.tx_buffer_full_flag = 1'b0;
      nxt_st.tx_busy_flag = 1'b1;
      tx_ev = 1'b1;
    end else if (tx_done && !st_ff.tx_buffer_full_flag && !wr_tx) begin
      nxt_st.tx_busy_flag = 1'b0;
    end

    nxt_st.rx_irq = rx_ev;
    nxt_st.tx_irq = tx_ev;

    // sticky interrupt status, write one to clear; set wins
    if (bus_go && avs_write && sel_ist && avs_byteenable[0]) begin
      nxt_st.ist = st_ff.ist & ~avs_writedata[IRQ_N-1:0];
    end
    if (bus_go && avs_write && sel_msk && avs_byteenable[0]) begin
      nxt_st.imask = avs_writedata[IRQ_N-1:0];
    end
    if (rx_ev) nxt_st.ist[IRQ_RX] = 1'b1;
    if (tx_ev) nxt_st.ist[IRQ_TX] = 1'b1;
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '{bus: BUS_IDLE, imask: RST_MASK, tbuf: RST_BYTE, tshift: RST_BYTE,
                 default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign avs_waitrequest = (avs_read || avs_write) && (st_ff.bus == BUS_IDLE);
  assign avs_readdata = st_ff.rdata;
  assign tx_start = st_ff.start;
  assign tx_data_out = st_ff.tshift;
  assign rx_interrupt_request = st_ff.rx_irq;
  assign tx_interrupt_request = st_ff.tx_irq;
  assign irq = |(st_ff.ist & st_ff.imask);
endmodule // uart_status_flag_logic

// File: tb/uart_flag_asserts.sv
// Purpose: port checks of the serial status flag block
// Assumes: single clock, async active-high reset
// Notes: bound to every instance of the top module
`timescale 1ns/100ps
module uart_flag_asserts
  import uart_flag_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // register bus
  input wire logic [uart_flag_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [uart_flag_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [uart_flag_pkg::DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  // datapath and requests
  input wire logic rx_frame_done,
  input wire logic tx_shift_idle,
  input wire logic tx_start,
  input wire logic [7:0] tx_data_out,
  input wire logic rx_interrupt_request,
  input wire logic tx_interrupt_request
);
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  property p_wait_first;
    $rose(avs_read) |-> avs_waitrequest;
  endproperty
  a_wait_first: assert property (p_wait_first) else $error("read answered without wait");
  property p_wait_one;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait longer than one cycle");
  property p_rx_cause;
    rx_interrupt_request |-> $past(rx_frame_done);
  endproperty
  a_rx_cause: assert property (p_rx_cause) else $error("rx request without frame");
  property p_tx_start;
    (avs_write && !avs_waitrequest && avs_address == OFS_TXDATA && avs_byteenable[0])
      ##1 tx_shift_idle |=> tx_start && tx_data_out == $past(avs_writedata[7:0], 2);
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("tx byte not started");
  property p_tx_irq;
    tx_start |-> ##[0:1] tx_interrupt_request;
  endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("no tx request at start");
  property p_start_pulse;
    tx_start |=> !tx_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("tx start too long");
  property p_unmapped;
    avs_read && !avs_waitrequest && avs_address == 5'h02 |-> avs_readdata == UNMAPPED_RD;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rd_hold;
    !avs_read |=> $stable(avs_readdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved while idle");
endmodule // uart_flag_asserts

bind uart_status_flag_logic uart_flag_asserts i_uart_flag_asserts (
  .clk_sys, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_byteenable, .avs_readdata, .avs_waitrequest, .rx_frame_done, .tx_shift_idle,
  .tx_start, .tx_data_out, .rx_interrupt_request, .tx_interrupt_request
);

// File: tb/uart_remote_model.sv
// Purpose: remote serial end: sends judged frames, consumes transmit bytes
// Assumes: frames arrive as one-cycle completion pulses
// Notes: released data, parity bit and stop lines show the inverse of the last value; parity_odd keeps it
`timescale 1ns/100ps
module uart_remote_model #(
  parameter int TX_CYC = 20
) (
  // clock
  input wire logic clk_sys,
  // transmit shifter
  input wire logic tx_start,
  output logic tx_shift_idle = 1'b1,
  output logic tx_done = 1'b0,
  // received frames
  output logic rx_frame_done = 1'b0,
  output logic [7:0] rx_frame_data = 8'h00,
  output logic rx_parity_bit = 1'b0,
  output logic rx_parity_en = 1'b1,
  output logic rx_parity_odd = 1'b0,
  output logic rx_stop_sample = 1'b1
);
  int cnt = 0;
  // a slow shifter so a second byte waits in the buffer
  always @(posedge clk_sys) begin
    tx_done <= 1'b0;
    if (tx_start) begin
      tx_shift_idle <= 1'b0;
      cnt <= TX_CYC;
    end else if (cnt == 1) begin
      tx_shift_idle <= 1'b1;
      tx_done <= 1'b1;
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
  task automatic send(input logic [7:0] d, input logic bad_par, input logic stop);
    rx_frame_done <= 1'b1;
    rx_frame_data <= d;
    rx_parity_odd <= d[0];
    rx_parity_bit <= ^d ^ d[0] ^ bad_par;
    rx_stop_sample <= stop;
    @(posedge clk_sys);
    rx_frame_done <= 1'b0;
    rx_frame_data <= ~d;
    rx_parity_bit <= ~rx_parity_bit;
    rx_stop_sample <= ~stop;
  endtask
endmodule // uart_remote_model

// File: tb/uart_status_flag_logic_bench.sv
// Purpose: self-checking bench of the serial status flag block
// Assumes: one wait state per bus access
// Notes: status bits 0 parity, 1 framing, 2 overrun, 3 rx full, 4 tx full, 5 tx busy
`timescale 1ns/100ps
module uart_status_flag_logic_bench;
  import uart_flag_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [ADDR_W-1:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic avs_waitrequest, tx_start, irq, rx_frame_done, rx_parity_bit, rx_parity_en;
  logic rx_parity_odd, rx_stop_sample, tx_shift_idle, tx_done, rx_interrupt_request;
  logic tx_interrupt_request;
  logic [7:0] rx_frame_data, tx_data_out;
  logic [31:0] avs_readdata, rd;
  int fails = 0, cmp_count = 0, cyc = 0;
  uart_status_flag_logic i_uart_status_flag_logic (.clk_sys, .sys_rst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .rx_frame_done, .rx_frame_data, .rx_parity_bit, .rx_parity_en,
    .rx_parity_odd, .rx_stop_sample, .tx_shift_idle, .tx_done, .tx_start, .tx_data_out,
    .rx_interrupt_request, .tx_interrupt_request, .irq);
  uart_remote_model i_uart_remote_model (.clk_sys, .tx_start, .tx_shift_idle, .tx_done,
    .rx_frame_done, .rx_frame_data, .rx_parity_bit, .rx_parity_en, .rx_parity_odd,
    .rx_stop_sample);
  initial forever #50 clk_sys = ~clk_sys;
  // ****************
  // access tasks
  // ****************
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // request held until the rising edge that sees waitrequest low; one idle edge between calls
  task automatic acc(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= wd;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rs(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), rd, e);
  endtask
  task automatic fr(input logic [7:0] d, input logic bad, input logic stop, input logic e);
    i_uart_remote_model.send(d, bad, stop);
    @(negedge clk_sys);
    chk("rx request", {31'h0, rx_interrupt_request}, {31'h0, e});
    @(posedge clk_sys);
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      stop_test;
    end
  end
  // ****************
  // tests
  // ****************
  initial begin
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    rs(OFS_STATUS, 32'h0);
    fr(8'h5a, 1'b1, 1'b1, 1'b1);
    rs(OFS_STATUS, 32'h9);
    acc(1'b0, OFS_RXDATA, 32'h0);
    rs(OFS_STATUS, 32'h0);
    fr(8'h3c, 1'b0, 1'b0, 1'b1);
    rs(OFS_STATUS, 32'ha);
    rs(OFS_RXDATA, 32'h3c);
    rs(OFS_STATUS, 32'h0);
    $display("test frame errors done");
    fr(8'h11, 1'b0, 1'b1, 1'b1);
    fr(8'h22, 1'b1, 1'b0, 1'b1);
    fr(8'h33, 1'b0, 1'b1, 1'b0);
    rs(OFS_STATUS, 32'hc);
    rs(OFS_RXDATA, 32'h11);
    rs(OFS_STATUS, 32'h0);
    fr(8'h66, 1'b0, 1'b1, 1'b1);
    rs(OFS_RXDATA, 32'h66);
    rs(OFS_STATUS, 32'h8);
    fr(8'h77, 1'b0, 1'b1, 1'b1);
    rs(OFS_RXDATA, 32'h66);
    rs(OFS_STATUS, 32'h4);
    rs(OFS_RXDATA, 32'h66);
    rs(OFS_STATUS, 32'h0);
    $display("test overrun done");
    avs_byteenable <= 4'h0;
    acc(1'b1, OFS_TXDATA, 32'h99);
    avs_byteenable <= 4'hf;
    rs(OFS_STATUS, 32'h0);
    acc(1'b1, OFS_TXDATA, 32'ha5);
    acc(1'b1, OFS_TXDATA, 32'h5a);
    rs(OFS_STATUS, 32'h30);
    do @(posedge clk_sys); while (tx_start !== 1'b1);
    rs(OFS_STATUS, 32'h20);
    do @(posedge clk_sys); while (tx_done !== 1'b1);
    rs(OFS_STATUS, 32'h0);
    $display("test transmit done");
    rs(OFS_IRQ_ST, 32'h3);
    acc(1'b1, OFS_IRQ_ST, 32'h3);
    acc(1'b0, OFS_IRQ_ST, 32'h0);
    chk("rx event bit", rd & 32'h1, 32'h0);
    rs(5'h02, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    acc(1'b1, OFS_IRQ_MASK, 32'h1);
    rs(OFS_IRQ_MASK, 32'h1);
    fr(8'h42, 1'b0, 1'b1, 1'b1);
    rs(OFS_IRQ_ST, 32'h1);
    chk("irq masked in", {31'h0, irq}, 32'h1);
    acc(1'b1, OFS_IRQ_ST, 32'h1);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    $display("test interrupt status done");
    stop_test;
  end
endmodule // uart_status_flag_logic_bench
